/* File: wac_pipe_model.sv */
// Purpose: pipeline model issuing system register moves to the bank
// Assumes: one move in flight; answer registered on the taking edge, read 1 ns after it
// Notes: released write data is inverted so stale data never looks valid
`timescale 1ns/1ns
module wac_pipe_model
   import wac_pkg::*;
(
   // clock
   input wire logic CLOCK,
   // move request out, answer in
   output wac_req_t REQ,
   input wire wac_resp_t RESP
);
   initial REQ = '0;
   ////////////////////////////////////////////////////////////////////////////
   // one move: raised after an edge, held through the taking edge
   task automatic access(input logic wr, input logic [1:0] lvl, input logic [3:0] crm,
      input logic [2:0] op2, input logic [63:0] wd, output wac_resp_t r);
      @(posedge CLOCK);
      #1;
      REQ.write = wr;
      REQ.level = lvl;
      REQ.op0 = WAC_OP0_SYS;
      REQ.op1 = WAC_OP1_KERN;
      REQ.crn = WAC_CRN_IMP;
      REQ.crm = crm;
      REQ.op2 = op2;
      REQ.wdata = wd;
      REQ.valid = 1'b1;
      @(posedge CLOCK);
      #1;
      REQ.valid = 1'b0;
      // scrambled, not held: a design reading stale data must fail
      REQ.wdata = ~wd;
      r = RESP;
   endtask
endmodule

/* File: wac_pkg.sv */
// Purpose: shared constants and types for the walk attribute / aux control bank
// Assumes: single core clock, synchronous active-high reset
// Notes: encodings are the system register select fields
package wac_pkg;
   localparam int WAC_DATA_W = 64;
   localparam logic [1:0] WAC_OP0_SYS = 2'h3;
   localparam logic [2:0] WAC_OP1_KERN = 3'h0;
   localparam logic [3:0] WAC_CRN_IMP = 4'hF;
   localparam logic [3:0] WAC_CRM_WALK = 4'h7;
   localparam logic [3:0] WAC_CRM_AUX = 4'h8;
   localparam logic [2:0] WAC_OP2_WALK = 3'h0;
   localparam logic [2:0] WAC_OP2_AUX5 = 3'h0;
   localparam logic [2:0] WAC_OP2_AUX6 = 3'h1;
   localparam logic [5:0] WAC_EC_SYSREG = 6'h18;
   localparam int WAC_WALK_LSB_UVAL = 12;
   localparam int WAC_WALK_LSB_LVAL = 8;
   localparam int WAC_WALK_LSB_UEN = 4;
   localparam int WAC_WALK_LSB_LEN = 0;
   localparam int WAC_WALK_USED_W = 16;
   localparam int WAC_HINT_W = 4;
   localparam logic [63:0] WAC_ZERO64 = 64'h0;
   localparam logic [15:0] WAC_WALK_RESET = 16'h0000;

   // exception levels
   localparam logic [1:0] WAC_USER_LEVEL = 2'h0;
   localparam logic [1:0] WAC_KERNEL_LEVEL = 2'h1;
   localparam logic [1:0] WAC_HYPERVISOR_LEVEL = 2'h2;
   localparam logic [1:0] WAC_MONITOR_LEVEL = 2'h3;

   // outcome of one access
   typedef enum logic [3:0]
   {
      WAC_DONE = 4'b0001,
      WAC_UNDEF = 4'b0010,
      WAC_TRAP_HYP = 4'b0100,
      WAC_TRAP_MON = 4'b1000
   } wac_outcome_t;

   // one system register move request
   typedef struct packed
   {
      logic valid;
      logic write;
      logic [1:0] level;
      logic [1:0] op0;
      logic [2:0] op1;
      logic [3:0] crn;
      logic [3:0] crm;
      logic [2:0] op2;
      logic [63:0] wdata;
   } wac_req_t;

   // trap controls from the wider core
   typedef struct packed
   {
      logic hyp_enabled;
      logic impdef_access_trap;
      logic hyp_aux_access_enable;
      logic mon_aux_access_enable;
   } wac_trapcfg_t;

   // response back to the pipeline
   typedef struct packed
   {
      logic valid;
      logic hit;
      logic [3:0] outcome;
      logic [5:0] ec;
      logic [63:0] rdata;
      logic rdata_we;
   } wac_resp_t;

   // all state of the bank
   typedef struct packed
   {
      logic [15:0] walk_attribute_control;
      logic [63:0] auxiliary_control_five;
      logic [63:0] auxiliary_control_six;
      wac_resp_t resp;
      logic [3:0] upper_hint;
      logic [3:0] lower_hint;
   } wac_state_t;
endpackage

/* File: wac_regs.sv */
// Purpose: walk attribute control and two reserved aux control registers
// Assumes: requests come from the pipeline on CLOCK; one per cycle at most
// Notes: answer one cycle after a valid request; hint outputs registered
//
// How it works
// - upper walks take hint values from bits 15..12
// - lower walks take hint values from bits 11..8
// - bits 7..4 enable upper walk hints
// - bits 3..0 enable lower walk hints
// - disabled hint bit is driven zero
// - user level access is undefined
// - kernel access traps to hypervisor when trap set
// - hypervisor walk register access never traps
// - kernel aux write checks hypervisor then monitor enables
// - hypervisor aux write traps if monitor disallows
// - monitor level accesses always complete
// - aux registers are 64 bits, all reserved
// - walk register select encoding 3,0,15,7,0
// - aux registers at 3,0,15,8 op2 0 and 1
`timescale 1ns/1ns
module wac_regs
   import wac_pkg::*;
(
   // clock, reset, enable
   input wire logic CLOCK,
   input wire logic RESET,
   input wire logic CLOCK_EN,
   // register move request and trap controls
   input wire wac_req_t REQ,
   input wire wac_trapcfg_t TRAP_CFG,
   // response
   output wac_resp_t RESP,
   // walk hint attributes, one set per translation base range
   output logic [3:0] UPPER_WALK_HINT,
   output logic [3:0] LOWER_WALK_HINT
);

   wac_state_t st_reg;
   wac_state_t st_next;

   logic sel_common;
   logic sel_walk;
   logic sel_aux5;
   logic sel_aux6;
   logic sel_any;
   logic sel_aux;
   wac_outcome_t outcome;
   logic [63:0] read_mux;
   logic [3:0] w_uval;
   logic [3:0] w_lval;
   logic [3:0] w_uen;
   logic [3:0] w_len;

   ////////////////////////////////////////////////////////////////////////
   // decode of the system register select fields
   assign sel_common = REQ.op0 == WAC_OP0_SYS && REQ.op1 == WAC_OP1_KERN
                       && REQ.crn == WAC_CRN_IMP;
   assign sel_walk = sel_common && REQ.crm == WAC_CRM_WALK
                     && REQ.op2 == WAC_OP2_WALK;
   assign sel_aux5 = sel_common && REQ.crm == WAC_CRM_AUX
                     && REQ.op2 == WAC_OP2_AUX5;
   assign sel_aux6 = sel_common && REQ.crm == WAC_CRM_AUX
                     && REQ.op2 == WAC_OP2_AUX6;
   assign sel_any = sel_walk || sel_aux5 || sel_aux6;
   assign sel_aux = sel_aux5 || sel_aux6;

   ////////////////////////////////////////////////////////////////////////
   // access permission by exception level; trap order follows priority
   always_comb
   begin
      outcome = WAC_DONE;
      unique case (REQ.level)
         WAC_USER_LEVEL:
         begin
            outcome = WAC_UNDEF;
         end
         WAC_KERNEL_LEVEL:
         begin
            if (TRAP_CFG.hyp_enabled && TRAP_CFG.impdef_access_trap)
               outcome = WAC_TRAP_HYP;
            else if (REQ.write && sel_aux && TRAP_CFG.hyp_enabled
                     && !TRAP_CFG.hyp_aux_access_enable)
               outcome = WAC_TRAP_HYP;
            else if (REQ.write && sel_aux && !TRAP_CFG.mon_aux_access_enable)
               outcome = WAC_TRAP_MON;
            else
               outcome = WAC_DONE;
         end
         WAC_HYPERVISOR_LEVEL:
         begin
            // walk register needs no check; aux writes ask the monitor
            if (REQ.write && sel_aux && !TRAP_CFG.mon_aux_access_enable)
               outcome = WAC_TRAP_MON;
            else
               outcome = WAC_DONE;
         end
         WAC_MONITOR_LEVEL:
         begin
            outcome = WAC_DONE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // read data; unused walk bits read as zero
   always_comb
   begin
      read_mux = WAC_ZERO64;
      if (sel_walk)
         read_mux = {{(WAC_DATA_W - WAC_WALK_USED_W){1'b0}},
                     st_reg.walk_attribute_control};
      else if (sel_aux5)
         read_mux = st_reg.auxiliary_control_five;
      else if (sel_aux6)
         read_mux = st_reg.auxiliary_control_six;
   end

   // field slices of the walk register
   assign w_uval = st_reg.walk_attribute_control[WAC_WALK_LSB_UVAL +: WAC_HINT_W];
   assign w_lval = st_reg.walk_attribute_control[WAC_WALK_LSB_LVAL +: WAC_HINT_W];
   assign w_uen = st_reg.walk_attribute_control[WAC_WALK_LSB_UEN +: WAC_HINT_W];
   assign w_len = st_reg.walk_attribute_control[WAC_WALK_LSB_LEN +: WAC_HINT_W];

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      st_next = st_reg;
      st_next.resp.valid = 1'b0;
      st_next.resp.rdata_we = 1'b0;
      // hint outputs are one cycle behind the register, so a write lands
      // on walks from the second cycle after the move
      st_next.upper_hint = w_uval & w_uen;
      st_next.lower_hint = w_lval & w_len;
      if (REQ.valid && sel_any)
      begin
         st_next.resp.valid = 1'b1;
         st_next.resp.hit = 1'b1;
         st_next.resp.outcome = outcome;
         st_next.resp.ec = (outcome == WAC_TRAP_HYP || outcome == WAC_TRAP_MON)
                           ? WAC_EC_SYSREG : 6'h00;
         st_next.resp.rdata = WAC_ZERO64;
         if (outcome == WAC_DONE)
         begin
            if (!REQ.write)
            begin
               st_next.resp.rdata = read_mux;
               st_next.resp.rdata_we = 1'b1;
            end
            else if (sel_walk)
               st_next.walk_attribute_control = REQ.wdata[WAC_WALK_USED_W-1:0];
            else if (sel_aux5)
               st_next.auxiliary_control_five = REQ.wdata;
            else
               st_next.auxiliary_control_six = REQ.wdata;
         end
      end
      else if (REQ.valid)
      begin
         // not ours: answer a miss so the pipeline can route it elsewhere
         st_next.resp.valid = 1'b1;
         st_next.resp.hit = 1'b0;
         st_next.resp.outcome = WAC_DONE;
         st_next.resp.ec = 6'h00;
         st_next.resp.rdata = WAC_ZERO64;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register; aux registers have no defined reset, zero chosen
   always_ff @(posedge CLOCK)
   begin
      if (RESET)
      begin
         st_reg <= '0;
         st_reg.walk_attribute_control <= WAC_WALK_RESET;
         st_reg.resp.outcome <= WAC_DONE;
      end
      else if (CLOCK_EN)
         st_reg <= st_next;
   end

   assign RESP = st_reg.resp;
   assign UPPER_WALK_HINT = st_reg.upper_hint;
   assign LOWER_WALK_HINT = st_reg.lower_hint;

   ////////////////////////////////////////////////////////////////////////
   // checks
   AST_USER_UNDEF: assert property (@(posedge CLOCK) disable iff (RESET)
      CLOCK_EN && REQ.valid && sel_any && REQ.level == WAC_USER_LEVEL
      |=> RESP.outcome == WAC_UNDEF && !RESP.rdata_we)
      else $error("user level access not undefined");
   AST_KERN_TRAP: assert property (@(posedge CLOCK) disable iff (RESET)
      CLOCK_EN && REQ.valid && sel_any && REQ.level == WAC_KERNEL_LEVEL
      && TRAP_CFG.hyp_enabled && TRAP_CFG.impdef_access_trap
      |=> RESP.outcome == WAC_TRAP_HYP && RESP.ec == WAC_EC_SYSREG)
      else $error("kernel access did not trap to hypervisor");
   AST_HYP_WALK: assert property (@(posedge CLOCK) disable iff (RESET)
      CLOCK_EN && REQ.valid && sel_walk && REQ.level == WAC_HYPERVISOR_LEVEL
      |=> RESP.outcome == WAC_DONE)
      else $error("hypervisor walk access refused");
   AST_KERN_AUX_MON: assert property (@(posedge CLOCK) disable iff (RESET)
      CLOCK_EN && REQ.valid && REQ.write && sel_aux && REQ.level == WAC_KERNEL_LEVEL
      && !TRAP_CFG.hyp_enabled && !TRAP_CFG.mon_aux_access_enable
      |=> RESP.outcome == WAC_TRAP_MON)
      else $error("kernel aux write not trapped to monitor");
   AST_HYP_AUX: assert property (@(posedge CLOCK) disable iff (RESET)
      CLOCK_EN && REQ.valid && REQ.write && sel_aux5
      && REQ.level == WAC_HYPERVISOR_LEVEL && TRAP_CFG.mon_aux_access_enable
      |=> st_reg.auxiliary_control_five == $past(REQ.wdata))
      else $error("hypervisor aux write lost");
   AST_MON_DONE: assert property (@(posedge CLOCK) disable iff (RESET)
      CLOCK_EN && REQ.valid && sel_any && REQ.level == WAC_MONITOR_LEVEL
      |=> RESP.outcome == WAC_DONE)
      else $error("monitor access refused");
   AST_HINT_MASK: assert property (@(posedge CLOCK) disable iff (RESET)
      CLOCK_EN ##1 CLOCK_EN |-> (UPPER_WALK_HINT & ~$past(w_uen)) == 4'h0
      && (LOWER_WALK_HINT & ~$past(w_len)) == 4'h0)
      else $error("disabled hint bit driven high");
   AST_HINT_VAL: assert property (@(posedge CLOCK) disable iff (RESET)
      CLOCK_EN |=> UPPER_WALK_HINT == ($past(w_uval) & $past(w_uen))
      && LOWER_WALK_HINT == ($past(w_lval) & $past(w_len)))
      else $error("hint output mismatch");
   AST_NO_CHANGE: assert property (@(posedge CLOCK) disable iff (RESET)
      CLOCK_EN && REQ.valid && outcome != WAC_DONE
      |=> $stable(st_reg.walk_attribute_control)
      && $stable(st_reg.auxiliary_control_five) && !RESP.rdata_we)
      else $error("refused access changed state");
endmodule

/* File: wac_regs_tb.sv */
// Purpose: self-checking bench for the walk attribute / aux control bank
// Assumes: moves issued through the pipeline model, trap controls from here
// Notes: clock enable dropped once to show a frozen bank ignores a move
`timescale 1ns/1ns
module wac_regs_tb;
   import wac_pkg::*;
   localparam logic [1:0] USR = WAC_USER_LEVEL;
   localparam logic [1:0] KRN = WAC_KERNEL_LEVEL;
   localparam logic [1:0] HYP = WAC_HYPERVISOR_LEVEL;
   localparam logic [1:0] MON = WAC_MONITOR_LEVEL;
   logic CLOCK = 1'b0;
   logic RESET = 1'b1;
   logic clk_en = 1'b1;
   wac_req_t req;
   wac_trapcfg_t cfg = '0;
   wac_resp_t resp;
   wac_resp_t r;
   logic [3:0] up_hint;
   logic [3:0] lo_hint;
   logic [15:0] vals [4] = '{16'hF0F0, 16'h0F0F, 16'h5A00, 16'hA5C3};
   int num_errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   ////////////////////////////////////////////////////////////////////////////
   // device and pipeline model
   wac_regs DUT (.CLOCK(CLOCK), .RESET(RESET), .CLOCK_EN(clk_en), .REQ(req),
      .TRAP_CFG(cfg), .RESP(resp), .UPPER_WALK_HINT(up_hint), .LOWER_WALK_HINT(lo_hint));
   wac_pipe_model pipe (.CLOCK(CLOCK), .REQ(req), .RESP(resp));
   initial forever #10 CLOCK = ~CLOCK;
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one move and its full answer; ec and write-back follow the outcome
   task automatic op(input logic wr, input logic [1:0] lvl, input logic [3:0] crm,
      input logic [2:0] op2, input logic [63:0] wd, input logic [3:0] oc, input logic [63:0] rd);
      pipe.access(wr, lvl, crm, op2, wd, r);
      check({r.valid, r.hit, r.outcome, r.ec}, {2'h3, oc, (oc[2] | oc[3]) ? WAC_EC_SYSREG : 6'h00});
      check(64'(r.rdata_we), 64'(~wr & oc[0]));
      check(r.rdata, rd);
   endtask
   task automatic finish_test();
      $display("checks=%0d errors=%0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // hang guard: the tests need under 80 cycles
   always @(posedge CLOCK)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         num_errors++;
         finish_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (5) @(posedge CLOCK);
      #1;
      RESET = 1'b0;
      check(64'({up_hint, lo_hint}), 64'h0);
      op(0, MON, WAC_CRM_WALK, WAC_OP2_WALK, 64'h0, WAC_DONE, 64'h0);
      $display("test reset done");
      // each pattern: upper/lower hints are value masked by enable
      foreach (vals[i])
      begin
         op(1, MON, WAC_CRM_WALK, WAC_OP2_WALK, {48'hFFFF_FFFF_FFFF, vals[i]}, WAC_DONE, 64'h0);
         op(0, MON, WAC_CRM_WALK, WAC_OP2_WALK, 64'h0, WAC_DONE, 64'(vals[i]));
         check(64'(up_hint), 64'(vals[i][15:12] & vals[i][7:4]));
         check(64'(lo_hint), 64'(vals[i][11:8] & vals[i][3:0]));
      end
      $display("test hints done");
      cfg = 4'b1111;
      op(1, USR, WAC_CRM_WALK, WAC_OP2_WALK, 64'h1234, WAC_UNDEF, 64'h0);
      op(0, USR, WAC_CRM_AUX, WAC_OP2_AUX5, 64'h0, WAC_UNDEF, 64'h0);
      op(1, KRN, WAC_CRM_WALK, WAC_OP2_WALK, 64'h1111, WAC_TRAP_HYP, 64'h0);
      op(0, KRN, WAC_CRM_AUX, WAC_OP2_AUX6, 64'h0, WAC_TRAP_HYP, 64'h0);
      op(0, MON, WAC_CRM_WALK, WAC_OP2_WALK, 64'h0, WAC_DONE, 64'hA5C3);
      op(1, HYP, WAC_CRM_WALK, WAC_OP2_WALK, 64'h00C3, WAC_DONE, 64'h0);
      cfg = 4'b1011;
      op(1, KRN, WAC_CRM_WALK, WAC_OP2_WALK, 64'h0077, WAC_DONE, 64'h0);
      op(0, KRN, WAC_CRM_WALK, WAC_OP2_WALK, 64'h0, WAC_DONE, 64'h0077);
      $display("test levels done");
      // aux writes: kernel checks hypervisor enable first, then monitor; then hypervisor and monitor levels
      cfg = 4'b1001;
      op(1, KRN, WAC_CRM_AUX, WAC_OP2_AUX5, 64'h1, WAC_TRAP_HYP, 64'h0);
      cfg = 4'b1010;
      op(1, KRN, WAC_CRM_AUX, WAC_OP2_AUX5, 64'h2, WAC_TRAP_MON, 64'h0);
      cfg = 4'b0000;
      op(1, KRN, WAC_CRM_AUX, WAC_OP2_AUX5, 64'h3, WAC_TRAP_MON, 64'h0);
      cfg = 4'b0001;
      op(1, KRN, WAC_CRM_AUX, WAC_OP2_AUX5, 64'hDEAD_BEEF_0123_4567, WAC_DONE, 64'h0);
      cfg = 4'b1110;
      op(1, HYP, WAC_CRM_AUX, WAC_OP2_AUX6, 64'h4, WAC_TRAP_MON, 64'h0);
      op(0, HYP, WAC_CRM_AUX, WAC_OP2_AUX6, 64'h0, WAC_DONE, 64'h0);
      cfg = 4'b1111;
      op(1, HYP, WAC_CRM_AUX, WAC_OP2_AUX6, 64'h8000_0000_0000_0001, WAC_DONE, 64'h0);
      op(1, HYP, WAC_CRM_AUX, WAC_OP2_AUX5, 64'h0123_4567_89AB_CDEF, WAC_DONE, 64'h0);
      op(0, HYP, WAC_CRM_AUX, WAC_OP2_AUX5, 64'h0, WAC_DONE, 64'h0123_4567_89AB_CDEF);
      cfg = 4'b1100;
      op(1, MON, WAC_CRM_AUX, WAC_OP2_AUX5, 64'hFEDC_BA98_7654_3210, WAC_DONE, 64'h0);
      op(0, MON, WAC_CRM_AUX, WAC_OP2_AUX5, 64'h0, WAC_DONE, 64'hFEDC_BA98_7654_3210);
      op(0, MON, WAC_CRM_AUX, WAC_OP2_AUX6, 64'h0, WAC_DONE, 64'h8000_0000_0000_0001);
      $display("test aux done");
      // unmatched select answers with no hit and changes nothing
      pipe.access(1, MON, 4'h9, 3'h0, 64'hFFFF, r);
      check({r.valid, r.hit, r.outcome, r.rdata_we}, {2'h2, WAC_DONE, 1'b0});
      op(0, MON, WAC_CRM_WALK, WAC_OP2_WALK, 64'h0, WAC_DONE, 64'h0077);
      $display("test miss done");
      // frozen bank: the move is lost and the last answer holds
      clk_en = 1'b0;
      pipe.access(1, MON, WAC_CRM_WALK, WAC_OP2_WALK, 64'h00FF, r);
      check({r.valid, r.rdata_we}, 2'h3);
      check(r.rdata, 64'h0077);
      clk_en = 1'b1;
      op(0, MON, WAC_CRM_WALK, WAC_OP2_WALK, 64'h0, WAC_DONE, 64'h0077);
      $display("test freeze done");
      // mid-run reset clears the walk register and the hints
      RESET = 1'b1;
      repeat (2) @(posedge CLOCK);
      #1;
      RESET = 1'b0;
      check(64'({up_hint, lo_hint}), 64'h0);
      op(0, MON, WAC_CRM_WALK, WAC_OP2_WALK, 64'h0, WAC_DONE, 64'h0);
      $display("test rerun reset done");
      finish_test();
   end
endmodule
